// ---- core/mosmcs_regs.vh ----
// register map, field positions and codes of the clock monitor and select block
`ifndef MOSMCS_REGS_VH
`define MOSMCS_REGS_VH

// byte offsets
`define MOSMCS_OFF_CPU_MODE_REGISTER 8'h00
`define MOSMCS_OFF_MISC 8'h04
`define MOSMCS_OFF_RDIV 8'h08
`define MOSMCS_OFF_STAT 8'h0c

// cpu mode register fields
`define MOSMCS_CPU_MODE_REGISTER_DIV_HI 7
`define MOSMCS_CPU_MODE_REGISTER_DIV_LO 6
`define MOSMCS_CPU_MODE_REGISTER_RC 5
`define MOSMCS_CPU_MODE_REGISTER_MSTOP 4
`define MOSMCS_CPU_MODE_REGISTER_OSTOP 3
`define MOSMCS_CPU_MODE_REGISTER_PM_HI 1
`define MOSMCS_CPU_MODE_REGISTER_PM_LO 0

// clock division codes in cpu mode bits 7:6
`define MOSMCS_DIV_M2 2'h0
`define MOSMCS_DIV_M8 2'h1
`define MOSMCS_DIV_ONCHIP 2'h2
`define MOSMCS_DIV_M1 2'h3

// reset value: on-chip clock selected, both oscillators running
`define MOSMCS_CPU_MODE_REGISTER_RST 8'h80

// misc register fields
`define MOSMCS_MISC_DET_EN 0
`define MOSMCS_MISC_RST_EN 1
`define MOSMCS_MISC_FLAG 2

// on-chip division codes
`define MOSMCS_RDIV_1 2'h0
`define MOSMCS_RDIV_2 2'h1
`define MOSMCS_RDIV_8 2'h2
`define MOSMCS_RDIV_128 2'h3

// divide counts minus one
`define MOSMCS_N1 7'h00
`define MOSMCS_N2 7'h01
`define MOSMCS_N8 7'h07
`define MOSMCS_N128 7'h7f

// status register fields
`define MOSMCS_STAT_ONMAIN 0
`define MOSMCS_STAT_ALIVE 1
`define MOSMCS_STAT_LOCK 2

`endif

// ---- core/mosmcs_top.v ----
// main oscillation stop monitor and cpu clock select with apb registers
// Overview of operation
// - detect-enable bit set activates on-chip supervision
// - detected main stop sets sticky flag
// - stop-reset-enable makes detection raise internal reset
// - internal stop reset keeps the flag
// - external reset clears the flag
// - writing zero to detect-enable clears flag
// - detect-enable survives internal stop reset
// - main clock ratios divide 2, 8, 1
// - on-chip ratios divide 1, 2, 8, 128
// - reset and switch to on-chip select /8
// - type and processor bits written once only
// - cpu period is 1, 2, 8 main periods
// - cpu mode bit fields 7:6, 4, 3
// - start on-chip, bit 5 picks ceramic/rc
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "mosmcs_regs.vh"

module mosmcs_top #(
  parameter STOP_WINDOW = 16,
  parameter RST_HOLD = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // oscillator side
  input wire main_osc_input,
  input wire onchip_osc_tick,
  output reg main_osc_enable,
  output reg onchip_osc_enable,
  output reg main_osc_rc,
  // cpu side
  output reg cpu_clk_tick,
  output reg [1:0] proc_mode,
  output reg osc_stop_rst
);

  // window counter width, enough for both parameters
  localparam CW = 16;
  localparam integer WIN_LAST_I = STOP_WINDOW - 1;
  localparam integer HOLD_LAST_I = RST_HOLD - 1;
  // cut to the counter width on purpose
  localparam [CW-1:0] WIN_LAST = WIN_LAST_I[CW-1:0];
  localparam [CW-1:0] HOLD_LAST = HOLD_LAST_I[CW-1:0];

  // register state
  reg [7:0] cpu_mode_register_r;
  reg cpu_mode_register_lock_r;
  reg det_en_r;
  reg rst_en_r;
  reg flag_r;
  reg [1:0] rdiv_r;

  // monitor state
  reg xs1_r;
  reg xs2_r;
  reg xs3_r;
  reg [CW-1:0] win_r;
  reg [CW-1:0] hold_r;
  reg alive_r;

  // divider state
  reg [6:0] div_cnt_r;
  reg on_main_r;

  // decoded bus strobes
  wire setup_ph;
  wire wr_acc;
  wire wr_cpu_mode_register;
  wire wr_misc;
  wire wr_rdiv;
  wire addr_ok;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign wr_cpu_mode_register = wr_acc & (paddr == `MOSMCS_OFF_CPU_MODE_REGISTER);
  assign wr_misc = wr_acc & (paddr == `MOSMCS_OFF_MISC);
  assign wr_rdiv = wr_acc & (paddr == `MOSMCS_OFF_RDIV);
  assign addr_ok = (paddr == `MOSMCS_OFF_CPU_MODE_REGISTER) | (paddr == `MOSMCS_OFF_MISC) |
                   (paddr == `MOSMCS_OFF_RDIV) | (paddr == `MOSMCS_OFF_STAT);

  // decoded mode fields
  wire [1:0] div_sel;
  wire on_main;
  wire monitor_on;
  wire main_edge;
  wire stop_evt;
  wire soft_rst;

  assign div_sel = cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_DIV_HI:`MOSMCS_CPU_MODE_REGISTER_DIV_LO];
  assign on_main = (div_sel != `MOSMCS_DIV_ONCHIP);
  assign monitor_on = det_en_r & ~cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_OSTOP];
  assign main_edge = xs2_r & ~xs3_r;
  assign stop_evt = monitor_on & onchip_osc_tick & ~main_edge &
                    (win_r == WIN_LAST);
  // internal stop reset reinitialises the cpu mode logic
  assign soft_rst = osc_stop_rst;

  // apb answer: one wait-free access phase, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~addr_ok;
    end
  end

  // read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph & ~pwrite) begin
      case (paddr)
        `MOSMCS_OFF_CPU_MODE_REGISTER: begin
          prdata <= {24'h000000, cpu_mode_register_r};
        end
        `MOSMCS_OFF_MISC: begin
          prdata <= {29'h0000_0000, flag_r, rst_en_r, det_en_r};
        end
        `MOSMCS_OFF_RDIV: begin
          prdata <= {30'h0000_0000, rdiv_r};
        end
        `MOSMCS_OFF_STAT: begin
          prdata <= {29'h0000_0000, cpu_mode_register_lock_r, alive_r, on_main};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // cpu mode register with once-only fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mode_register_r <= `MOSMCS_CPU_MODE_REGISTER_RST;
      cpu_mode_register_lock_r <= 1'b0;
    end else if (soft_rst) begin
      cpu_mode_register_r <= `MOSMCS_CPU_MODE_REGISTER_RST;
      cpu_mode_register_lock_r <= 1'b0;
    end else if (wr_cpu_mode_register) begin
      cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_DIV_HI:`MOSMCS_CPU_MODE_REGISTER_DIV_LO] <=
        pwdata[`MOSMCS_CPU_MODE_REGISTER_DIV_HI:`MOSMCS_CPU_MODE_REGISTER_DIV_LO];
      cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_MSTOP] <= pwdata[`MOSMCS_CPU_MODE_REGISTER_MSTOP];
      cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_OSTOP] <= pwdata[`MOSMCS_CPU_MODE_REGISTER_OSTOP];
      if (!cpu_mode_register_lock_r) begin
        cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_RC] <= pwdata[`MOSMCS_CPU_MODE_REGISTER_RC];
        cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_PM_HI:`MOSMCS_CPU_MODE_REGISTER_PM_LO] <=
          pwdata[`MOSMCS_CPU_MODE_REGISTER_PM_HI:`MOSMCS_CPU_MODE_REGISTER_PM_LO];
      end
      cpu_mode_register_lock_r <= 1'b1;
    end
  end

  // on-chip division ratio register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdiv_r <= `MOSMCS_RDIV_8;
    end else if (soft_rst) begin
      rdiv_r <= `MOSMCS_RDIV_8;
    end else if (on_main_r & ~on_main) begin
      // forced on main to on-chip switch
      rdiv_r <= `MOSMCS_RDIV_8;
    end else if (wr_rdiv) begin
      rdiv_r <= pwdata[1:0];
    end
  end

  // monitor control bits, untouched by the internal stop reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_en_r <= 1'b0;
      rst_en_r <= 1'b0;
    end else if (wr_misc) begin
      det_en_r <= pwdata[`MOSMCS_MISC_DET_EN];
      rst_en_r <= pwdata[`MOSMCS_MISC_RST_EN];
    end
  end

  // sticky stop flag, a detection wins over a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (stop_evt) begin
      flag_r <= 1'b1;
    end else if (wr_misc & ~pwdata[`MOSMCS_MISC_DET_EN]) begin
      flag_r <= 1'b0;
    end
  end

  // main clock sampler, first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= main_osc_input;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  // on-chip ticks counted since the last main edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= {CW{1'b0}};
      alive_r <= 1'b0;
    end else if (!monitor_on | main_edge) begin
      win_r <= {CW{1'b0}};
      alive_r <= main_edge | (alive_r & ~monitor_on);
    end else if (onchip_osc_tick) begin
      if (win_r == WIN_LAST) begin
        win_r <= {CW{1'b0}};
        alive_r <= 1'b0;
      end else begin
        win_r <= win_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // internal reset pulse of fixed length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_stop_rst <= 1'b0;
      hold_r <= {CW{1'b0}};
    end else if (stop_evt & rst_en_r) begin
      osc_stop_rst <= 1'b1;
      hold_r <= {CW{1'b0}};
    end else if (osc_stop_rst) begin
      if (hold_r == HOLD_LAST) begin
        osc_stop_rst <= 1'b0;
      end else begin
        hold_r <= hold_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // divide count for the active source
  reg [6:0] div_last;
  always @* begin
    div_last = `MOSMCS_N8;
    case (div_sel)
      `MOSMCS_DIV_M2: begin
        div_last = `MOSMCS_N2;
      end
      `MOSMCS_DIV_M8: begin
        div_last = `MOSMCS_N8;
      end
      `MOSMCS_DIV_M1: begin
        div_last = `MOSMCS_N1;
      end
      default: begin
        case (rdiv_r)
          `MOSMCS_RDIV_1: begin
            div_last = `MOSMCS_N1;
          end
          `MOSMCS_RDIV_2: begin
            div_last = `MOSMCS_N2;
          end
          `MOSMCS_RDIV_128: begin
            div_last = `MOSMCS_N128;
          end
          default: begin
            div_last = `MOSMCS_N8;
          end
        endcase
      end
    endcase
  end

  // source ticks: main edges or on-chip ticks
  wire src_tick;
  assign src_tick = on_main ? main_edge : onchip_osc_tick;

  // cpu clock divider, restarts when the source changes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 7'h00;
      cpu_clk_tick <= 1'b0;
      on_main_r <= 1'b0;
    end else begin
      on_main_r <= on_main;
      if (on_main_r != on_main) begin
        div_cnt_r <= 7'h00;
        cpu_clk_tick <= 1'b0;
      end else if (src_tick) begin
        // one tick per N source periods
        if (div_cnt_r >= div_last) begin
          div_cnt_r <= 7'h00;
          cpu_clk_tick <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 7'h01;
          cpu_clk_tick <= 1'b0;
        end
      end else begin
        cpu_clk_tick <= 1'b0;
      end
    end
  end

  // oscillator controls and mode outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_enable <= 1'b1;
      onchip_osc_enable <= 1'b1;
      main_osc_rc <= 1'b0;
      proc_mode <= 2'h0;
    end else begin
      main_osc_enable <= ~cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_MSTOP];
      onchip_osc_enable <= ~cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_OSTOP];
      main_osc_rc <= cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_RC];
      proc_mode <= cpu_mode_register_r[`MOSMCS_CPU_MODE_REGISTER_PM_HI:`MOSMCS_CPU_MODE_REGISTER_PM_LO];
    end
  end

endmodule

// ---- bench/mosmcs_top_sva.sv ----
// port assertions for the clock monitor and select block
`timescale 1ns/1ns
module mosmcs_chk #(
  parameter STOP_WINDOW = 16,
  parameter RST_HOLD = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // oscillators
  input wire main_osc_input,
  input wire onchip_osc_tick,
  input wire main_osc_enable,
  input wire onchip_osc_enable,
  input wire main_osc_rc,
  // cpu side
  input wire cpu_clk_tick,
  input wire [1:0] proc_mode,
  input wire osc_stop_rst
);
  logic [7:0] hold_r;
  logic wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write to the cpu mode register
  assign wr = psel && penable && pready && pwrite && paddr == 8'h00;
  // length of the internal reset pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_r <= 8'h00;
    else hold_r <= osc_stop_rst ? hold_r + 8'h01 : 8'h00;
  end
  a_rst_short: assert property (osc_stop_rst |-> hold_r < RST_HOLD)
    else $error("internal reset too long");
  a_rst_full: assert property ($fell(osc_stop_rst) |-> hold_r == RST_HOLD)
    else $error("internal reset too short");
  a_stop_ref: assert property ($rose(osc_stop_rst) |-> onchip_osc_enable)
    else $error("stop seen without on-chip reference");
  a_alive_nostop: assert property ($rose(osc_stop_rst) |->
    !(!$past(main_osc_input, 4) && $past(main_osc_input, 3)))
    else $error("stop declared right after a main edge");
  a_rst_onchip: assert property (osc_stop_rst ##1 osc_stop_rst |=> main_osc_enable
    && onchip_osc_enable && !main_osc_rc && proc_mode == 2'h0)
    else $error("internal reset left cpu mode set");
  a_main_ctrl: assert property (wr && !osc_stop_rst |-> ##2
    main_osc_enable == !$past(pwdata[4], 2))
    else $error("main oscillator control wrong");
  a_onchip_ctrl: assert property (wr && !osc_stop_rst |-> ##2
    onchip_osc_enable == !$past(pwdata[3], 2))
    else $error("on-chip oscillator control wrong");
  a_mode_cause: assert property ($changed(proc_mode) || $changed(main_osc_rc) |->
    $past(wr) || $past(wr, 2) || $past(osc_stop_rst) || $past(osc_stop_rst, 2))
    else $error("mode bits changed with no cause");
endmodule

bind mosmcs_top mosmcs_chk #(.STOP_WINDOW(STOP_WINDOW), .RST_HOLD(RST_HOLD)) u_mosmcs_chk (.*);

// ---- bench/mosmcs_osc_model.sv ----
// oscillator pair seen by the block: main level and on-chip ticks
`timescale 1ns/1ns
module mosmcs_osc_model (
  // clock
  input wire pclk,
  // bench controls
  input wire run,
  input wire [3:0] half,
  // block side
  input wire main_osc_enable,
  input wire onchip_osc_enable,
  output logic main_osc_input,
  output logic onchip_osc_tick
);
  logic [3:0] cnt_r = 4'h0;
  initial main_osc_input = 1'b0;
  initial onchip_osc_tick = 1'b0;
  // reference ticks every cycle while enabled
  always @(posedge pclk) onchip_osc_tick <= onchip_osc_enable;
  // main level toggles each half period, freezes when dead
  always @(posedge pclk) begin
    if (run && main_osc_enable) begin
      cnt_r <= (cnt_r >= half - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r >= half - 4'h1) main_osc_input <= ~main_osc_input;
    end
  end
endmodule

// ---- bench/main_osc_stop_monitor_clock_select_test.sv ----
// self-checking bench: ratios, locks and stop monitor
`timescale 1ns/1ns
module main_osc_stop_monitor_clock_select_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 1, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, w1, seed = 32'h2f24226b;
  logic pready, pslverr, mosc, otick, men, oen, rc, tick, srst;
  logic [1:0] pm;
  logic [3:0] half = 4'h3;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, k;
  always #20 pclk = ~pclk;
  mosmcs_top #(.STOP_WINDOW(12), .RST_HOLD(2)) u_mosmcs_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_osc_input(mosc),
    .onchip_osc_tick(otick), .main_osc_enable(men), .onchip_osc_enable(oen),
    .main_osc_rc(rc), .cpu_clk_tick(tick), .proc_mode(pm), .osc_stop_rst(srst));
  mosmcs_osc_model u_mosmcs_osc_model (.pclk(pclk), .run(run), .half(half),
    .main_osc_enable(men), .onchip_osc_enable(oen), .main_osc_input(mosc),
    .onchip_osc_tick(otick));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // apb transfer, answer taken at the edge where pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // wait for the answer; only the hang guard ends a stuck wait
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, rd, e);
  endtask
  // cycles between cpu ticks, measured after the divider settles
  task period(input int e);
    repeat (3) begin
      k = 0;
      do begin @(posedge pclk); k++; end while (tick !== 1'b1 && k < 600);
    end
    chk("tick period", k, e);
  endtask
  task xrst;
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin n_mismatch++; summarize; end
  end
  initial begin
    xrst;
    rdchk("cpu_mode_register", 8'h00, 32'h80);
    rdchk("misc", 8'h04, 0);
    rdchk("rdiv", 8'h08, 2);
    rdchk("unmapped", 8'h10, 0);
    chk("slverr", err, 1);
    chk("rc", rc, 0);
    period(8);
    rdchk("stat", 8'h0c, 2);
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h08, i);
      period(i == 0 ? 1 : i == 1 ? 2 : i == 2 ? 8 : 128);
    end
    $display("on-chip ratios done");
    // flag-only monitoring is tried while on the on-chip clock
    apb(1, 8'h04, 1);
    run <= 0;
    repeat (40) @(posedge pclk);
    chk("stop rst", srst, 0);
    rdchk("misc flag", 8'h04, 5);
    // main restarts first so no detection can meet the clearing write
    run <= 1;
    repeat (20) @(posedge pclk);
    apb(1, 8'h04, 0);
    rdchk("misc clear", 8'h04, 0);
    // main clock runs a while before it is selected
    seed = xs(seed);
    half <= 4'h2 + seed[1:0];
    repeat (40) @(posedge pclk);
    // ceramic chosen, so double speed is allowed
    w1 = {24'h0, 6'h00, seed[9:8]};
    apb(1, 8'h00, w1);
    rdchk("cpu_mode_register", 8'h00, w1);
    rdchk("stat", 8'h0c, 7);
    period(4 * half);
    apb(1, 8'h00, {24'h0, 6'h18, ~seed[9:8]});
    rdchk("cpu_mode_register lock", 8'h00, w1 | 32'h40);
    chk("mode", pm, seed[9:8]);
    period(16 * half);
    apb(1, 8'h00, 32'hc0);
    period(2 * half);
    apb(1, 8'h08, 0);
    apb(1, 8'h00, 32'h80);
    repeat (2) @(posedge pclk);
    rdchk("rdiv", 8'h08, 2);
    $display("main ratios done");
    apb(1, 8'h00, 32'h00);
    apb(1, 8'h04, 3);
    run <= 0;
    k = 0;
    do begin @(posedge pclk); k++; end while (srst !== 1'b1 && k < 300);
    chk("stop rst", srst, 1);
    run <= 1;
    repeat (40) @(posedge pclk);
    rdchk("cpu_mode_register", 8'h00, 32'h80);
    rdchk("misc kept", 8'h04, 7);
    // internal reset unlocks the once-only fields again
    apb(1, 8'h00, 32'ha0);
    rdchk("cpu_mode_register relock", 8'h00, 32'ha0);
    chk("rc", rc, 1);
    xrst;
    rdchk("misc ext", 8'h04, 0);
    $display("monitor done");
    summarize;
  end
endmodule
